// [verilog/clb_pkg.sv]
/*
  constants for the logic array block: sizes, macrocell
  configuration fields, register offsets and encodings.
  assumes one block of sixteen macrocells behind apb.
*/
package clb_pkg;
  localparam int MC_N = 16;
  localparam int IN_N = 36;
  localparam int PT_N = 5;
  localparam int SHR_BASE = 80;
  localparam int TERM_N = 96;
  localparam int TW_PER = 4;
  localparam int TERM_WORDS = 384;
  localparam int CHAIN_N = 8;
  localparam int BORROW_MAX = 3;
  localparam int GOE_N = 6;
  // macrocell configuration word fields
  localparam int CFG_W = 19;
  localparam int F_TYPE = 0;
  localparam int F_BYP = 2;
  localparam int F_CLK = 3;
  localparam int F_GSEL = 5;
  localparam int F_GCLR = 6;
  localparam int F_INV = 7;
  localparam int F_STEER = 8;
  localparam int F_BORROW = 12;
  localparam int F_LEND = 14;
  localparam int F_FAST = 15;
  localparam int F_OE = 16;
  // steering bits: terms 1..4 leave the or gate
  localparam int S_PRE = 0;
  localparam int S_CLR = 1;
  localparam int S_CLK = 2;
  localparam int S_K = 3;
  typedef enum logic [1:0] {CLB_FF_D, CLB_FF_T, CLB_FF_JK, CLB_FF_SR} clb_ff_t;
  typedef enum logic [1:0] {CLB_CK_GLOBAL, CLB_CK_GLOBAL_CE, CLB_CK_ARRAY, CLB_CK_NONE} clb_ck_t;
  // pin output enable select
  localparam logic [2:0] OE_OFF = 3'h0;
  localparam logic [2:0] OE_ON = 3'h1;
  // block input select word, global enable word
  localparam int IS_EN = 6;
  localparam int GOE_INV = 3;
  localparam logic [5:0] SRC_IO = 6'h04;
  localparam logic [5:0] SRC_MC = 6'h14;
  // apb byte addresses
  localparam logic [11:0] A_MC = 12'h000;
  localparam logic [11:0] A_IN = 12'h040;
  localparam logic [11:0] A_GOE = 12'h0d0;
  localparam logic [11:0] A_GCLK = 12'h0e8;
  localparam logic [11:0] A_STAT = 12'h0f0;
  localparam logic [11:0] A_OEST = 12'h0f4;
  localparam logic [11:0] A_TERM = 12'h400;
  localparam logic [11:0] A_END = 12'ha00;
endpackage

// [verilog/clb_macrocell.sv]
/*
  one macrocell: term steering, xor, configurable register.
  assumes clock pins are sampled in the clk domain and
  edges arrive as one-cycle pulses from the block.
*/
`timescale 1ns/1ps
module clb_macrocell #(
  parameter bit EXTENDED = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [18:0] cfg,
  input wire logic [4:0] pt,
  input wire logic borrow_sum,
  input wire logic [1:0] gclk_rise,
  input wire logic gclr_n,
  input wire logic fast_d,
  output logic grp,
  output logic q,
  output logic mc_out
);
  logic q_reg;
  logic q_next;
  logic ctl_prev_reg;
  logic tick;
  logic ff_val;
  clb_pkg::clb_ck_t mode;
  clb_pkg::clb_ff_t ftype;

  // term steering to register controls
  wire [3:0] steer = cfg[clb_pkg::F_STEER +: 4];
  wire pre = steer[clb_pkg::S_PRE] & pt[1];
  wire gclr = cfg[clb_pkg::F_GCLR] & ~gclr_n;
  wire clr = (steer[clb_pkg::S_CLR] & pt[2]) | gclr;
  wire ctl = steer[clb_pkg::S_CLK] & pt[3];
  wire k_in = steer[clb_pkg::S_K] & pt[4];
  // or gate, lending and xor polarity
  wire own = cfg[clb_pkg::F_LEND] ? 1'b0 : grp;
  wire sum = (own | borrow_sum) ^ cfg[clb_pkg::F_INV];
  wire fast = EXTENDED & cfg[clb_pkg::F_FAST];
  wire d_in = fast ? fast_d : sum;
  wire gedge = gclk_rise[cfg[clb_pkg::F_GSEL]];
  assign mode = clb_pkg::clb_ck_t'(cfg[clb_pkg::F_CLK +: 2]);
  assign ftype = clb_pkg::clb_ff_t'(cfg[clb_pkg::F_TYPE +: 2]);
  assign grp = |(pt & {~steer, 1'b1});

  // clocking choice
  always_comb begin
    case (mode)
      clb_pkg::CLB_CK_GLOBAL: tick = gedge;
      clb_pkg::CLB_CK_GLOBAL_CE: tick = gedge & ctl;
      clb_pkg::CLB_CK_ARRAY: tick = ctl & ~ctl_prev_reg;
      default: tick = 1'b0;
    endcase
  end

  // flip-flop personality
  always_comb begin
    case (ftype)
      clb_pkg::CLB_FF_D: ff_val = d_in;
      clb_pkg::CLB_FF_T: ff_val = q_reg ^ d_in;
      clb_pkg::CLB_FF_JK: ff_val = d_in ? (~k_in | ~q_reg) : (~k_in & q_reg);
      clb_pkg::CLB_FF_SR: ff_val = d_in | (~k_in & q_reg);
      default: ff_val = q_reg;
    endcase
  end

  // clear beats preset; both act without a clock edge
  assign q_next = clr ? 1'b0 : (pre ? 1'b1 : (tick ? ff_val : q_reg));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= 1'b0;
      ctl_prev_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
      ctl_prev_reg <= ctl;
    end
  end

  assign q = q_reg;
  assign mc_out = cfg[clb_pkg::F_BYP] ? d_in : q_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence ce_low_edge;
    mode == clb_pkg::CLB_CK_GLOBAL_CE && gedge && !ctl && !clr && !pre;
  endsequence
  sequence t_edge;
    mode == clb_pkg::CLB_CK_GLOBAL && ftype == clb_pkg::CLB_FF_T && gedge && d_in && !clr && !pre;
  endsequence

  ce_hold_a: assert property (ce_low_edge |=> q_reg == $past(q_reg))
    else $error("register changed with clock enable low");
  gclr_a: assert property (gclr |=> !q_reg)
    else $error("global clear did not clear");
  preset_a: assert property (pre && !clr |=> q_reg)
    else $error("preset did not set");
  toggle_a: assert property (t_edge |=> q_reg != $past(q_reg))
    else $error("t register did not toggle");
  arr_clk_a: assert property (mode == clb_pkg::CLB_CK_ARRAY && !ctl && !clr && !pre |=> q_reg == $past(q_reg))
    else $error("array clocked register moved without edge");
  fast_a: assert property (fast && ftype == clb_pkg::CLB_FF_D && mode == clb_pkg::CLB_CK_GLOBAL && gedge
    && !clr && !pre |=> q_reg == $past(fast_d))
    else $error("fast input not captured");
endmodule

// [verilog/clb_logic_block.sv]
/*
  logic array block of sixteen macrocells with routing input
  selection, product terms, expanders and pin control.
  assumes apb master on clk; all pins synchronous to clk.
*/
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - block groups sixteen macrocells fed by thirty-six routed inputs plus globals
// - five terms per macrocell, each to or gate or register controls
// - register acts as d, t, jk or sr, or is bypassed
// - clock is global, global with enable, or a product term
// - basic: one clock pin; extended: two clocks, either pin, either polarity
// - term preset and clear are asynchronous and active high
// - global clear pin, when low, may clear each register
// - all registers start low after power-up
// - extended: each pin has a direct path to a register input
// - sixteen inverted shareable terms feed back to all macrocells
// - or gate takes own five plus up to three borrowed sets
// - lending runs in chains of eight from lower neighbours only
// - routing matrix carries dedicated inputs, pins and macrocell outputs
// - each routed signal enters through an and gate with a cell
// - pin enable is a global enable, or tied off or on
// - basic: two global enables, each active while its pin is low
// - extended: six global enables from pins, macrocells or enable inputs
// - pin feedback and macrocell feedback are independent paths
// - four dedicated inputs serve as general inputs or global controls
module clb_logic_block #(
  parameter bit EXTENDED = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic primary_clock_pin,
  input wire logic secondary_clock_pin,
  input wire logic global_clear_pin_n,
  input wire logic output_enable_pin_a,
  input wire logic output_enable_pin_b,
  input wire logic [15:0] io_in,
  output logic [15:0] io_out,
  output logic [15:0] io_oe_b
);
  localparam int MC_N = clb_pkg::MC_N;
  localparam int IN_N = clb_pkg::IN_N;
  localparam int CW = clb_pkg::CFG_W;

  // configuration and term storage
  logic [CW-1:0] mc_cfg_reg [MC_N];
  logic [6:0] insel_reg [IN_N];
  logic [3:0] goe_cfg_reg [clb_pkg::GOE_N];
  logic [3:0] gclk_cfg_reg;
  logic [31:0] term_reg [clb_pkg::TERM_WORDS];
  logic [1:0] gclk_prev_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [31:0] rd_val;
  logic rd_err;

  // internal nets
  logic [IN_N-1:0] blk_in;
  logic [IN_N-1:0] in_en;
  logic [clb_pkg::TERM_N-1:0] pt;
  logic [MC_N-1:0] grp;
  logic [MC_N-1:0] lend;
  logic [MC_N-1:0] borrow_sum;
  logic [MC_N-1:0] mc_q;
  logic [MC_N-1:0] mc_out;
  logic [1:0] gclk;
  logic [1:0] gclk_rise;
  logic [5:0] goe;

  // word offset of an address from a region base
  function automatic logic [8:0] woff(input logic [11:0] a, input logic [11:0] b);
    logic [11:0] d;
    d = a - b;
    woff = d[10:2];
  endfunction

  // one product term: and over selected true and complement literals
  function automatic logic term_fn(input logic [31:0] w0, input logic [31:0] w1,
    input logic [31:0] w2, input logic [31:0] w3, input logic [51:0] lit);
    logic [51:0] tm;
    logic [51:0] cm;
    tm = {w1[19:0], w0};
    cm = {w3[19:0], w2};
    term_fn = (|{tm, cm}) & (&(~tm | lit)) & (&(~cm | ~lit));
  endfunction

  // or of lent groups from up to three lower neighbours in the chain
  function automatic logic borrow_or(input logic [15:0] g, input logic [15:0] ln,
    input logic [1:0] n, input int k);
    logic r;
    int p;
    r = 1'b0;
    p = k % clb_pkg::CHAIN_N;
    for (int j = 1; j <= clb_pkg::BORROW_MAX; j++) begin
      if (j <= int'(n) && j <= p) begin
        if (ln[k-j]) begin
          r = r | g[k-j];
        end
      end
    end
    borrow_or = r;
  endfunction

  // apb decode
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  wire algn = paddr[1:0] == 2'h0;
  wire hit_mc = paddr < clb_pkg::A_IN;
  wire hit_in = paddr >= clb_pkg::A_IN && paddr < clb_pkg::A_GOE;
  wire hit_goe = paddr >= clb_pkg::A_GOE && paddr < clb_pkg::A_GCLK;
  wire hit_gclk = paddr == clb_pkg::A_GCLK;
  wire hit_stat = paddr == clb_pkg::A_STAT;
  wire hit_oest = paddr == clb_pkg::A_OEST;
  wire hit_term = paddr >= clb_pkg::A_TERM && paddr < clb_pkg::A_END;
  wire [8:0] in_off = woff(paddr, clb_pkg::A_IN);
  wire [8:0] goe_off = woff(paddr, clb_pkg::A_GOE);
  wire [8:0] term_off = woff(paddr, clb_pkg::A_TERM);
  wire [3:0] mc_i = paddr[5:2];
  wire [5:0] in_i = in_off[5:0];
  wire [2:0] goe_i = goe_off[2:0];

  // read mux; status words show register and pin state
  always_comb begin
    rd_val = 32'h0;
    rd_err = 1'b0;
    if (!algn) begin
      rd_err = 1'b1;
    end else if (hit_mc) begin
      rd_val = {13'h0, mc_cfg_reg[mc_i]};
    end else if (hit_in) begin
      rd_val = {25'h0, insel_reg[in_i]};
    end else if (hit_goe) begin
      rd_val = {28'h0, goe_cfg_reg[goe_i]};
    end else if (hit_gclk) begin
      rd_val = {28'h0, gclk_cfg_reg};
    end else if (hit_stat) begin
      rd_val = {16'h0, mc_q};
    end else if (hit_oest) begin
      rd_val = {16'h0, ~io_oe_b};
    end else if (hit_term) begin
      rd_val = term_reg[term_off];
    end else begin
      rd_err = 1'b1;
    end
  end

  // read data and error are captured in the setup cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= rd_val;
      pslverr_reg <= rd_err;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign pready = 1'b1;

  // configuration writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < MC_N; i++) begin
        mc_cfg_reg[i] <= '0;
      end
      for (int i = 0; i < IN_N; i++) begin
        insel_reg[i] <= 7'h0;
      end
      for (int i = 0; i < clb_pkg::GOE_N; i++) begin
        goe_cfg_reg[i] <= 4'h0;
      end
      gclk_cfg_reg <= 4'h0;
    end else if (wr && algn) begin
      if (hit_mc) begin
        mc_cfg_reg[mc_i] <= pwdata[CW-1:0];
      end
      if (hit_in) begin
        insel_reg[in_i] <= pwdata[6:0];
      end
      if (hit_goe) begin
        goe_cfg_reg[goe_i] <= pwdata[3:0];
      end
      if (hit_gclk) begin
        gclk_cfg_reg <= pwdata[3:0];
      end
    end
  end

  // term store; cleared terms read as inactive
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < clb_pkg::TERM_WORDS; i++) begin
        term_reg[i] <= 32'h0;
      end
    end else if (wr && algn && hit_term) begin
      term_reg[term_off] <= pwdata;
    end
  end

  // routing matrix sources: dedicated inputs, pins, macrocells
  wire [35:0] src = {mc_out, io_in, output_enable_pin_b, output_enable_pin_a,
    global_clear_pin_n, primary_clock_pin};
  wire [63:0] src_ext = {28'h0, src};

  // block inputs, each through an and with its enable cell
  generate
    for (genvar j = 0; j < IN_N; j++) begin : g_in
      assign in_en[j] = insel_reg[j][clb_pkg::IS_EN];
      assign blk_in[j] = in_en[j] & src_ext[insel_reg[j][5:0]];
    end
  endgenerate

  // product terms; shareable terms see only block inputs
  wire [15:0] shr_b = ~pt[clb_pkg::TERM_N-1:clb_pkg::SHR_BASE];
  wire [51:0] lit = {shr_b, blk_in};
  wire [51:0] lit_shr = {16'h0, blk_in};
  generate
    for (genvar t = 0; t < clb_pkg::TERM_N; t++) begin : g_pt
      if (t < clb_pkg::SHR_BASE) begin : g_loc
        assign pt[t] = term_fn(term_reg[t*4], term_reg[t*4+1],
          term_reg[t*4+2], term_reg[t*4+3], lit);
      end else begin : g_shr
        assign pt[t] = term_fn(term_reg[t*4], term_reg[t*4+1],
          term_reg[t*4+2], term_reg[t*4+3], lit_shr);
      end
    end
  endgenerate

  // global clocks from the clock pins
  generate
    for (genvar i = 0; i < 2; i++) begin : g_clk
      wire pin = gclk_cfg_reg[2*i] ? secondary_clock_pin : primary_clock_pin;
      assign gclk[i] = EXTENDED ? (pin ^ gclk_cfg_reg[2*i+1]) : primary_clock_pin;
    end
  endgenerate

  // clock edges seen in the clk domain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gclk_prev_reg <= 2'h0;
    end else begin
      gclk_prev_reg <= gclk;
    end
  end

  assign gclk_rise = gclk & ~gclk_prev_reg;

  // global output enables
  wire [7:0] goe_src = {2'h0, mc_out[1:0], io_in[1:0], output_enable_pin_b, output_enable_pin_a};
  generate
    for (genvar i = 0; i < clb_pkg::GOE_N; i++) begin : g_goe
      wire ext = goe_src[goe_cfg_reg[i][2:0]] ^ goe_cfg_reg[i][clb_pkg::GOE_INV];
      if (i == 0) begin : g_a
        assign goe[i] = EXTENDED ? ext : ~output_enable_pin_a;
      end else if (i == 1) begin : g_b
        assign goe[i] = EXTENDED ? ext : ~output_enable_pin_b;
      end else begin : g_x
        assign goe[i] = EXTENDED ? ext : 1'b0;
      end
    end
  endgenerate

  // macrocells with parallel expander chains
  wire [7:0] oe_tab = {goe, 2'b10};
  generate
    for (genvar k = 0; k < MC_N; k++) begin : g_mc
      assign lend[k] = mc_cfg_reg[k][clb_pkg::F_LEND];
      assign borrow_sum[k] = borrow_or(grp, lend, mc_cfg_reg[k][clb_pkg::F_BORROW +: 2], k);
      clb_macrocell #(
        .EXTENDED(EXTENDED)
      ) u_mc (
        .clk(clk),
        .rst_b(rst_b),
        .cfg(mc_cfg_reg[k]),
        .pt(pt[k*clb_pkg::PT_N +: clb_pkg::PT_N]),
        .borrow_sum(borrow_sum[k]),
        .gclk_rise(gclk_rise),
        .gclr_n(global_clear_pin_n),
        .fast_d(io_in[k]),
        .grp(grp[k]),
        .q(mc_q[k]),
        .mc_out(mc_out[k])
      );
      assign io_oe_b[k] = ~oe_tab[mc_cfg_reg[k][clb_pkg::F_OE +: 3]];
    end
  endgenerate

  assign io_out = mc_out;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence mc0_write;
    psel && penable && pwrite && paddr == clb_pkg::A_MC;
  endsequence

  blk_gate_a: assert property ((blk_in & ~in_en) == 36'h0)
    else $error("disabled block input not low");
  route_pin_a: assert property (in_en[0] && insel_reg[0][5:0] == clb_pkg::SRC_IO |-> blk_in[0] == io_in[0])
    else $error("pin not routed to block input");
  pin_fb_a: assert property (in_en[1] && insel_reg[1][5:0] == clb_pkg::SRC_MC |-> blk_in[1] == mc_out[0])
    else $error("macrocell feedback not routed");
  goe_basic_a: assert property (!EXTENDED |-> goe[1:0] == ~{output_enable_pin_b, output_enable_pin_a})
    else $error("basic global enable wrong");
  goe_ext_a: assert property (EXTENDED && goe_cfg_reg[0] == 4'h8 |-> goe[0] == !output_enable_pin_a)
    else $error("extended global enable wrong");
  gclk_sel_a: assert property (EXTENDED && gclk_cfg_reg == 4'h1 |-> gclk[0] == secondary_clock_pin)
    else $error("global clock selection wrong");
  power_low_a: assert property ($rose(rst_b) |-> mc_q == 16'h0)
    else $error("register not low after reset");
  chain_end_a: assert property (borrow_sum[0] == 1'b0 && borrow_sum[8] == 1'b0)
    else $error("chain bottom borrowed");
  no_borrow_a: assert property (mc_cfg_reg[3][clb_pkg::F_BORROW +: 2] == 2'h0 |-> !borrow_sum[3])
    else $error("borrowed without sets");
  pin_tie_a: assert property (mc_cfg_reg[0][clb_pkg::F_OE +: 3] == clb_pkg::OE_OFF |-> io_oe_b[0])
    else $error("tied-off pin driven");
  cfg_write_a: assert property (mc0_write |=> mc_cfg_reg[0] == $past(pwdata[CW-1:0]))
    else $error("configuration write lost");
endmodule

// [tb/clb_pin_partner.sv]
/*
  outside logic at the block's pins: clock, clear and enable
  pins, and the level on each shared io pin.
  assumes the block drives pin k with io_out[k] while io_oe_b[k] is low.
*/
`timescale 1ns/1ps
module clb_pin_partner (
  input wire logic clk,
  input wire logic [15:0] io_out,
  input wire logic [15:0] io_oe_b,
  output logic primary_clock_pin,
  output logic secondary_clock_pin,
  output logic global_clear_pin_n,
  output logic output_enable_pin_a,
  output logic output_enable_pin_b,
  output logic [15:0] io_in
);
  logic [15:0] ext_reg;

  // quiet pin levels from time zero
  initial begin
    ext_reg = 16'h0000;
    primary_clock_pin = 1'b0;
    secondary_clock_pin = 1'b0;
    global_clear_pin_n = 1'b1;
    output_enable_pin_a = 1'b0;
    output_enable_pin_b = 1'b0;
  end

  // wire level: the block wins where it drives, else the outside value
  assign io_in = (io_oe_b & ext_reg) | (~io_oe_b & io_out);

  // outside value for undriven pins
  task set_io(input logic [15:0] v);
    @(posedge clk);
    ext_reg <= v;
  endtask

  // one high cycle on a clock pin, then still again
  task pulse(input logic sec);
    @(posedge clk);
    if (sec) begin
      secondary_clock_pin <= 1'b1;
    end else begin
      primary_clock_pin <= 1'b1;
    end
    @(posedge clk);
    primary_clock_pin <= 1'b0;
    secondary_clock_pin <= 1'b0;
  endtask

  // dedicated control pins: 0 clear, 1 enable a, 2 enable b
  task set_pin(input int which, input logic v);
    @(posedge clk);
    case (which)
      0: global_clear_pin_n <= v;
      1: output_enable_pin_a <= v;
      default: output_enable_pin_b <= v;
    endcase
  endtask
endmodule

// [tb/cpld_logic_block_macrocells_tb_top.sv]
/*
  self-checking bench for the logic array block: registers over apb,
  clocking, clears, expanders and pin enables.
  assumes clb_pin_partner at the pins and zero-wait apb.
*/
`timescale 1ns/1ps
module cpld_logic_block_macrocells_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ck_a, ck_b, clr_n, oe_a, oe_b;
  logic [15:0] io_in, io_out, io_oe_b;
  int fail_count = 0;
  int tests_run = 0;

  // 50 mhz clock
  always #10 clk = ~clk;

  clb_logic_block #(.EXTENDED(1'b1)) i_dut (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .primary_clock_pin(ck_a), .secondary_clock_pin(ck_b),
    .global_clear_pin_n(clr_n), .output_enable_pin_a(oe_a), .output_enable_pin_b(oe_b),
    .io_in(io_in), .io_out(io_out), .io_oe_b(io_oe_b));

  clb_pin_partner i_pins (.clk(clk), .io_out(io_out), .io_oe_b(io_oe_b), .primary_clock_pin(ck_a),
    .secondary_clock_pin(ck_b), .global_clear_pin_n(clr_n), .output_enable_pin_a(oe_a),
    .output_enable_pin_b(oe_b), .io_in(io_in));

  // counts, verdict, end of run
  task report_and_stop();
    $display("counts: %0d checks, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer: setup, then access until pready at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      $display("wrong value at %0t: no apb answer", $time);
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    check({31'h0, e}, 32'h0, "write error flag");
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp, "read data");
    check({31'h0, e}, {31'h0, exp_err}, "read error flag");
  endtask

  task ticks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task pin(input int k, input logic e, input string what);
    check({31'h0, io_out[k]}, {31'h0, e}, what);
  endtask

  task t_reset();
    check({16'h0, io_oe_b}, 32'h0000ffff, "enables after reset");
    check({16'h0, io_out}, 32'h0, "outputs after reset");
    rd(clb_pkg::A_STAT, 32'h0, 1'b0);
    $display("test reset finished");
  endtask

  // block input 0 takes pin 4; term 0 of macrocell 0 is that input
  task t_dff();
    wr(clb_pkg::A_IN, 32'h00000048);
    wr(clb_pkg::A_TERM, 32'h00000001);
    wr(clb_pkg::A_MC, 32'h00010000);
    i_pins.set_io(16'h0010);
    i_pins.pulse(1'b0);
    ticks(3);
    pin(0, 1'b1, "d capture high");
    check({16'h0, io_oe_b}, 32'h0000fffe, "pin 0 driven");
    rd(clb_pkg::A_STAT, 32'h1, 1'b0);
    rd(clb_pkg::A_OEST, 32'h1, 1'b0);
    i_pins.set_io(16'hffef);
    i_pins.pulse(1'b0);
    ticks(3);
    pin(0, 1'b0, "d capture low");
    $display("test dff finished");
  endtask

  task t_clock_select();
    wr(clb_pkg::A_GCLK, 32'h00000001);
    i_pins.set_io(16'h0010);
    i_pins.pulse(1'b0);
    ticks(3);
    pin(0, 1'b0, "primary pin ignored");
    i_pins.pulse(1'b1);
    ticks(3);
    pin(0, 1'b1, "secondary pin clocks");
    wr(clb_pkg::A_GCLK, 32'h00000000);
    $display("test clock select finished");
  endtask

  // term 3 steered to the enable; empty term keeps it low
  task t_enable();
    wr(clb_pkg::A_MC, 32'h00010408);
    i_pins.set_io(16'h0000);
    i_pins.pulse(1'b0);
    ticks(3);
    pin(0, 1'b1, "held while enable low");
    wr(clb_pkg::A_TERM + 12'h038, 32'h00000001);
    i_pins.pulse(1'b0);
    ticks(3);
    pin(0, 1'b0, "loads while enable high");
    wr(clb_pkg::A_TERM + 12'h038, 32'h00000000);
    $display("test enable finished");
  endtask

  task t_clear();
    wr(clb_pkg::A_MC, 32'h00010040);
    i_pins.set_io(16'h0010);
    i_pins.pulse(1'b0);
    ticks(3);
    pin(0, 1'b1, "set before clear");
    i_pins.set_pin(0, 1'b0);
    ticks(2);
    pin(0, 1'b0, "global clear");
    i_pins.set_pin(0, 1'b1);
    $display("test clear finished");
  endtask

  // term 1 drives preset with no clock at all
  task t_preset();
    i_pins.set_io(16'h0000);
    wr(clb_pkg::A_MC, 32'h00010100);
    wr(clb_pkg::A_TERM + 12'h010, 32'h00000001);
    ticks(2);
    pin(0, 1'b0, "preset term low");
    i_pins.set_io(16'h0010);
    ticks(3);
    pin(0, 1'b1, "preset term high");
    wr(clb_pkg::A_TERM + 12'h010, 32'h00000000);
    $display("test preset finished");
  endtask

  task t_bypass();
    wr(clb_pkg::A_MC, 32'h00010004);
    ticks(1);
    pin(0, 1'b1, "bypass high");
    i_pins.set_io(16'h0000);
    ticks(1);
    pin(0, 1'b0, "bypass low");
    $display("test bypass finished");
  endtask

  // mc0 lends to mc1; mc7 lends but mc8 sits in the other chain
  task t_borrow();
    wr(clb_pkg::A_MC, 32'h00004004);
    wr(clb_pkg::A_MC + 12'h004, 32'h00011004);
    wr(clb_pkg::A_MC + 12'h01c, 32'h00004004);
    wr(clb_pkg::A_TERM + 12'h230, 32'h00000001);
    wr(clb_pkg::A_MC + 12'h020, 32'h00011004);
    i_pins.set_io(16'h0010);
    ticks(1);
    pin(1, 1'b1, "borrowed set");
    pin(0, 1'b0, "lent group leaves own or");
    pin(8, 1'b0, "no borrow across chains");
    $display("test borrow finished");
  endtask

  // term 0 uses only the inverted shareable term 80
  task t_share();
    wr(clb_pkg::A_MC, 32'h00010004);
    wr(clb_pkg::A_TERM, 32'h00000000);
    wr(clb_pkg::A_TERM + 12'h004, 32'h00000010);
    wr(clb_pkg::A_TERM + 12'h500, 32'h00000001);
    ticks(1);
    pin(0, 1'b0, "inverted expander low");
    i_pins.set_io(16'h0000);
    ticks(1);
    pin(0, 1'b1, "inverted expander high");
    $display("test share finished");
  endtask

  task t_goe();
    wr(clb_pkg::A_MC, 32'h00020004);
    wr(clb_pkg::A_GOE, 32'h00000000);
    i_pins.set_pin(1, 1'b1);
    ticks(1);
    check({31'h0, io_oe_b[0]}, 32'h0, "true enable on");
    i_pins.set_pin(1, 1'b0);
    ticks(1);
    check({31'h0, io_oe_b[0]}, 32'h1, "true enable off");
    wr(clb_pkg::A_GOE, 32'h00000008);
    ticks(1);
    check({31'h0, io_oe_b[0]}, 32'h0, "complement enable");
    wr(clb_pkg::A_MC, 32'h00030004);
    wr(clb_pkg::A_GOE + 12'h004, 32'h00000001);
    i_pins.set_pin(2, 1'b1);
    ticks(1);
    check({31'h0, io_oe_b[0]}, 32'h0, "enable b on");
    i_pins.set_pin(2, 1'b0);
    ticks(1);
    check({31'h0, io_oe_b[0]}, 32'h1, "enable b off");
    $display("test goe finished");
  endtask

  // t register toggles, pin fast path, then array clock from term 3
  task t_modes();
    wr(clb_pkg::A_MC, 32'h00010001);
    i_pins.pulse(1'b0);
    ticks(3);
    pin(0, 1'b0, "t toggles low");
    i_pins.pulse(1'b0);
    ticks(3);
    pin(0, 1'b1, "t toggles high");
    wr(clb_pkg::A_MC, 32'h00008000);
    i_pins.pulse(1'b0);
    ticks(3);
    pin(0, 1'b0, "fast input low");
    i_pins.set_io(16'h0001);
    i_pins.pulse(1'b0);
    ticks(3);
    pin(0, 1'b1, "fast input high");
    wr(clb_pkg::A_MC, 32'h00010410);
    wr(clb_pkg::A_TERM + 12'h030, 32'h00000001);
    i_pins.set_io(16'h0010);
    ticks(3);
    pin(0, 1'b0, "array clock edge");
    $display("test modes finished");
  endtask

  task t_apb();
    rd(12'h300, 32'h0, 1'b1);
    rd(12'hffc, 32'h0, 1'b1);
    rd(12'h002, 32'h0, 1'b1);
    wr(clb_pkg::A_STAT, 32'h0000ffff);
    rd(clb_pkg::A_STAT, 32'h0, 1'b0);
    rd(clb_pkg::A_MC, 32'h00010410, 1'b0);
    rd(clb_pkg::A_GOE, 32'h00000008, 1'b0);
    wr(clb_pkg::A_TERM + 12'h5fc, 32'hfffc0000);
    rd(clb_pkg::A_TERM + 12'h5fc, 32'hfffc0000, 1'b0);
    $display("test apb finished");
  endtask

  // reset for two cycles, then the scenarios in turn
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    ticks(2);
    t_reset();
    t_dff();
    t_clock_select();
    t_enable();
    t_clear();
    t_preset();
    t_bypass();
    t_borrow();
    t_share();
    t_goe();
    t_modes();
    t_apb();
    report_and_stop();
  end
endmodule
